// File: bus_port_pkg.sv
// What this block does
// - write strobe low marks external or register writes
// - early write select, abandoned without write strobe
// - early write select falls with address drive
// - master drives write select, slave samples it
// - memory may hold acknowledge low for waits
// - device pulls acknowledge low on peer register access waits
// - slave pulls master acknowledge low for waits
// - master keeps acknowledge at last driven level
// - suspend floats bus three cycles later, sdram pins driven
// - access under suspend stalls until suspend ends
// - suspend only for deadlock recovery
// - three interrupts, edge or level, asynchronous
// - twelve flags, each input or output
// - host requests bus, master floats and grants
// - sdram control stays driven while bus released
// - host request beats a simultaneous peer request
// - grant held while host request stays asserted
// - host chip select is low and asynchronous
// - ready low inserts host access wait states
// - ready open drain after reset, config selects drive
// - ready driven only with select and request
// - dma channel nine request, low, asynchronous
// - asynchronous inputs synchronised before use
package bus_port_pkg;
  localparam int IRQ_W = 3;
  localparam int FLAG_W = 12;
  localparam int DEV_SYNC_W = 9 + IRQ_W + FLAG_W;
  localparam int HOST_SYNC_W = 3 + FLAG_W;
  localparam logic [3:0] ACK_LATENCY_CYC = 4'h5;
  // device configuration word
  localparam int READY_DRIVE_MODE_POS = 3;
  localparam logic [31:0] SYSTEM_CONFIGURATION_REGISTER_RESET = 32'h00000000;
  // controller register offsets
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] ACCESS_OFS = 8'h04;
  localparam logic [7:0] FLAG_OUT_OFS = 8'h08;
  localparam logic [7:0] FLAG_DIR_OFS = 8'h0C;
  localparam logic [7:0] STATUS_OFS = 8'h10;
  // control, access and status register fields
  localparam int CTRL_W = 9;
  localparam int CB_REQ = 0;
  localparam int CB_CS = 1;
  localparam int CB_SUSP = 2;
  localparam int CB_DMA = 3;
  localparam int CB_PEER = 4;
  localparam int CB_ACKHOLD = 5;
  localparam int CB_IRQ = 6;
  localparam int AB_GO = 0;
  localparam int AB_WRITE = 1;
  localparam int SB_GRANT = 0;
  localparam int SB_READY = 1;
  localparam int SB_BUSY = 2;
  localparam int SB_ACK = 3;
  localparam int SB_FLAG = 16;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef enum logic [2:0] {D_IDLE, D_ADDR, D_STROBE, D_HOST, D_PEER} dev_state_t;
  typedef enum logic [1:0] {H_IDLE, H_WAIT, H_ADDR, H_STROBE} host_state_t;

  // byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] m;
    m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge = (old & ~m) | (data & m);
  endfunction
endpackage

// File: link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface link_if;
  import bus_port_pkg::*;
  // device end drives
  logic dev_wr_o, dev_wr_oe, dev_sw_o, dev_sw_oe, dev_ack_o, dev_ack_oe;
  logic dev_ready_o, dev_ready_oe, host_grant_n, addr_bus_oe, sdram_ctl_oe;
  logic [FLAG_W-1:0] dev_flag_o, dev_flag_oe;
  // host end drives
  logic host_wr_o, host_wr_oe, host_sw_o, host_sw_oe, host_ack_o, host_ack_oe;
  logic host_request_n, chip_select_n, suspend_bus_float_n, dma_request_channel_nine_n;
  logic peer_bus_request_n;
  logic [IRQ_W-1:0] irq_n;
  logic [FLAG_W-1:0] host_flag_o, host_flag_oe;
  // resolved wire levels, pulled high when undriven
  logic wr_n, early_write_select_n, ack, ack_driven, host_wait_ready;
  logic [FLAG_W-1:0] flag;
  assign wr_n = (dev_wr_oe | host_wr_oe) ? ((dev_wr_o | ~dev_wr_oe) & (host_wr_o | ~host_wr_oe)) : 1'b1;
  assign early_write_select_n = (dev_sw_o | ~dev_sw_oe) & (host_sw_o | ~host_sw_oe);
  assign ack = (dev_ack_o | ~dev_ack_oe) & (host_ack_o | ~host_ack_oe);
  assign ack_driven = dev_ack_oe | host_ack_oe;
  assign host_wait_ready = dev_ready_o | ~dev_ready_oe;
  assign flag = (dev_flag_o | ~dev_flag_oe) & (host_flag_o | ~host_flag_oe);
  modport dev_end (
    output dev_wr_o, dev_wr_oe, dev_sw_o, dev_sw_oe, dev_ack_o, dev_ack_oe,
    output dev_ready_o, dev_ready_oe, host_grant_n, addr_bus_oe, sdram_ctl_oe, dev_flag_o, dev_flag_oe,
    input host_request_n, chip_select_n, suspend_bus_float_n, dma_request_channel_nine_n,
    input peer_bus_request_n, irq_n, wr_n, early_write_select_n, ack, ack_driven, flag
  );
  modport host_end (
    output host_wr_o, host_wr_oe, host_sw_o, host_sw_oe, host_ack_o, host_ack_oe,
    output host_request_n, chip_select_n, suspend_bus_float_n, dma_request_channel_nine_n,
    output peer_bus_request_n, irq_n, host_flag_o, host_flag_oe,
    input host_grant_n, host_wait_ready, ack, flag
  );
endinterface
`default_nettype wire

// File: sync2.sv
`timescale 1ns/1ps
`default_nettype none
module sync2 #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;
  // first stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// File: bus_port_device.sv
`timescale 1ns/1ps
`default_nettype none
module bus_port_device
  import bus_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  link_if.dev_end lnk,
  input wire logic access_req,
  input wire logic access_write,
  input wire logic access_abort,
  output logic access_done,
  output logic access_stalled,
  input wire logic iop_ready,
  output logic iop_access,
  output logic iop_write,
  input wire logic system_configuration_register_write,
  input wire logic [31:0] system_configuration_register_wdata,
  output logic [31:0] system_configuration_register_rdata,
  input wire logic [IRQ_W-1:0] irq_edge_mode,
  input wire logic [IRQ_W-1:0] irq_clear,
  output logic [IRQ_W-1:0] irq_pending,
  input wire logic [FLAG_W-1:0] flag_dir,
  input wire logic [FLAG_W-1:0] flag_out,
  output logic [FLAG_W-1:0] flag_in,
  output logic dma_nine_request,
  output logic host_granted
);
  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [DEV_SYNC_W-1:0] raw_w;
  logic [DEV_SYNC_W-1:0] sync_q;
  logic hbr_n_s, cs_n_s, susp_n_s, peer_n_s, dma_n_s, wr_n_s, sw_n_s, ack_s, ack_drv_s;
  logic [IRQ_W-1:0] irq_n_s;
  logic [FLAG_W-1:0] flag_s;

  // every pin from the far side passes two flip-flops
  assign raw_w = {lnk.host_request_n, lnk.chip_select_n, lnk.suspend_bus_float_n,
                  lnk.peer_bus_request_n, lnk.dma_request_channel_nine_n, lnk.wr_n,
                  lnk.early_write_select_n, lnk.ack, lnk.ack_driven, lnk.irq_n, lnk.flag};
  assign {hbr_n_s, cs_n_s, susp_n_s, peer_n_s, dma_n_s, wr_n_s, sw_n_s, ack_s, ack_drv_s,
          irq_n_s, flag_s} = sync_q;

  sync2 #(
    .W(DEV_SYNC_W),
    .RST_VAL({DEV_SYNC_W{1'b1}})
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d(raw_w),
    .q(sync_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // bus ownership and master access sequencing
  dev_state_t state_r;
  dev_state_t state_nxt;
  logic write_r;
  logic ack_keep_r;
  logic [3:0] wait_cnt_r;
  logic wr_sel;
  logic own_nxt;
  logic drive_nxt;
  logic ack_wait_done;

  assign wr_sel = (state_r == D_IDLE) ? access_write : write_r;
  assign ack_wait_done = (wait_cnt_r >= ACK_LATENCY_CYC) && ack_keep_r;
  assign own_nxt = (state_nxt == D_IDLE) || (state_nxt == D_ADDR) || (state_nxt == D_STROBE);
  assign drive_nxt = own_nxt && susp_n_s;

  // next state: host first, then peer, then own access
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      D_IDLE: begin
        if (!hbr_n_s) begin
          state_nxt = D_HOST;
        end else if (!peer_n_s) begin
          state_nxt = D_PEER;
        end else if (access_req && susp_n_s) begin
          state_nxt = D_ADDR;
        end
      end
      D_ADDR: begin
        if (susp_n_s) begin
          state_nxt = access_abort ? D_IDLE : D_STROBE;
        end
      end
      D_STROBE: begin
        if (susp_n_s && ack_wait_done) begin
          state_nxt = D_IDLE;
        end
      end
      D_HOST: begin
        if (hbr_n_s) begin
          state_nxt = D_IDLE;
        end
      end
      D_PEER: begin
        if (peer_n_s) begin
          state_nxt = D_IDLE;
        end
      end
      default: begin
        state_nxt = D_IDLE;
      end
    endcase
  end

  // state, latched direction and the acknowledge keeper
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= D_IDLE;
      write_r <= 1'b0;
      ack_keep_r <= 1'b1;
      wait_cnt_r <= 4'h0;
    end else begin
      state_r <= state_nxt;
      write_r <= wr_sel;
      if (ack_drv_s) begin
        ack_keep_r <= ack_s;
      end
      if (state_r != D_STROBE) begin
        wait_cnt_r <= 4'h0;
      end else if (wait_cnt_r < ACK_LATENCY_CYC) begin
        wait_cnt_r <= wait_cnt_r + 4'h1;
      end
    end
  end

  // master strobes, address drive and grant
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lnk.dev_sw_oe <= 1'b0;
      lnk.dev_sw_o <= 1'b1;
      lnk.dev_wr_oe <= 1'b0;
      lnk.dev_wr_o <= 1'b1;
      lnk.addr_bus_oe <= 1'b0;
      lnk.sdram_ctl_oe <= 1'b1;
      lnk.host_grant_n <= 1'b1;
      host_granted <= 1'b0;
      access_done <= 1'b0;
      access_stalled <= 1'b0;
    end else begin
      lnk.addr_bus_oe <= drive_nxt;
      lnk.dev_sw_oe <= drive_nxt;
      lnk.dev_sw_o <= !(state_nxt == D_ADDR && wr_sel);
      lnk.dev_wr_oe <= drive_nxt;
      lnk.dev_wr_o <= !(state_nxt == D_STROBE && wr_sel);
      lnk.sdram_ctl_oe <= 1'b1;
      lnk.host_grant_n <= !(state_nxt == D_HOST);
      host_granted <= (state_nxt == D_HOST);
      access_done <= (state_r == D_STROBE || state_r == D_ADDR) && (state_nxt == D_IDLE);
      access_stalled <= access_req && !susp_n_s && own_nxt;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // slave side: register access by host or peer
  logic iop_sel;
  logic iop_async;
  logic iop_sync;
  logic ready_gate;
  logic ready_val;

  assign iop_sel = (state_r == D_HOST || state_r == D_PEER) && !cs_n_s;
  assign iop_async = iop_sel && !hbr_n_s;
  assign iop_sync = iop_sel && hbr_n_s;
  assign ready_gate = !cs_n_s && !hbr_n_s;
  assign ready_val = !(iop_async && !iop_ready);

  // wait-state drivers and access report
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      lnk.dev_ack_oe <= 1'b0;
      lnk.dev_ack_o <= 1'b0;
      lnk.dev_ready_oe <= 1'b0;
      lnk.dev_ready_o <= 1'b1;
      iop_access <= 1'b0;
      iop_write <= 1'b0;
    end else begin
      // pull ack low while waiting, then drive it high one cycle before release
      lnk.dev_ack_oe <= (iop_sync && !iop_ready) || (lnk.dev_ack_oe && !lnk.dev_ack_o);
      lnk.dev_ack_o <= !(iop_sync && !iop_ready);
      lnk.dev_ready_o <= ready_val;
      lnk.dev_ready_oe <= ready_gate && (system_configuration_register_rdata[READY_DRIVE_MODE_POS] || !ready_val);
      iop_access <= iop_sel;
      iop_write <= iop_sel && (!sw_n_s || !wr_n_s);
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // configuration, interrupts, flags and dma request
  logic [IRQ_W-1:0] irq_lvl;
  logic [IRQ_W-1:0] irq_prev_r;
  logic [IRQ_W-1:0] irq_nxt;

  assign irq_lvl = ~irq_n_s;
  // edge mode is sticky and set beats clear; level mode follows the line
  assign irq_nxt = (irq_edge_mode & ((irq_pending & ~irq_clear) | (irq_lvl & ~irq_prev_r)))
                 | (~irq_edge_mode & irq_lvl);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      system_configuration_register_rdata <= SYSTEM_CONFIGURATION_REGISTER_RESET;
      irq_prev_r <= '0;
      irq_pending <= '0;
      lnk.dev_flag_oe <= '0;
      lnk.dev_flag_o <= '1;
      flag_in <= '1;
      dma_nine_request <= 1'b0;
    end else begin
      if (system_configuration_register_write) begin
        system_configuration_register_rdata <= system_configuration_register_wdata;
      end
      irq_prev_r <= irq_lvl;
      irq_pending <= irq_nxt;
      lnk.dev_flag_oe <= flag_dir;
      lnk.dev_flag_o <= flag_out;
      flag_in <= flag_s;
      dma_nine_request <= !dma_n_s;
    end
  end
endmodule
`default_nettype wire

// File: bus_port_host.sv
`timescale 1ns/1ps
`default_nettype none
module bus_port_host
  import bus_port_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  link_if.host_end lnk,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  //////////////////////////////////////////////////////////////////////////////
  // input synchronisers
  logic [HOST_SYNC_W-1:0] sync_q;
  logic grant_n_s, ready_s, ack_s;
  logic [FLAG_W-1:0] flag_s;
  assign {grant_n_s, ready_s, ack_s, flag_s} = sync_q;

  sync2 #(
    .W(HOST_SYNC_W),
    .RST_VAL({HOST_SYNC_W{1'b1}})
  ) u_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .d({lnk.host_grant_n, lnk.host_wait_ready, lnk.ack, lnk.flag}),
    .q(sync_q)
  );

  //////////////////////////////////////////////////////////////////////////////
  // register slave
  logic aw_got_r, w_got_r;
  logic [7:0] aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0] w_strb_r;
  logic [CTRL_W-1:0] ctrl_r;
  logic [FLAG_W-1:0] flag_out_r, flag_dir_r;
  logic aw_hs, w_hs, ar_hs, do_write, busy, wr_hit, rd_hit, start;
  logic [31:0] rd_mux;
  host_state_t state_r, state_nxt;
  logic acc_write_r;
  logic [3:0] wait_cnt_r;

  assign aw_hs = awvalid && awready;
  assign w_hs = wvalid && wready;
  assign ar_hs = arvalid && arready;
  assign do_write = aw_got_r && w_got_r && !bvalid;
  assign busy = (state_r != H_IDLE);
  assign wr_hit = (aw_addr_r == CTRL_OFS) || (aw_addr_r == ACCESS_OFS) || (aw_addr_r == FLAG_OUT_OFS)
                || (aw_addr_r == FLAG_DIR_OFS) || (aw_addr_r == STATUS_OFS);
  assign rd_hit = (araddr == CTRL_OFS) || (araddr == ACCESS_OFS) || (araddr == FLAG_OUT_OFS)
                || (araddr == FLAG_DIR_OFS) || (araddr == STATUS_OFS);
  assign start = do_write && (aw_addr_r == ACCESS_OFS) && wstrb_go(w_strb_r) && w_data_r[AB_GO] && !busy;
  assign rd_mux = (araddr == CTRL_OFS) ? 32'(ctrl_r)
                : (araddr == ACCESS_OFS) ? 32'(acc_write_r) << AB_WRITE
                : (araddr == FLAG_OUT_OFS) ? 32'(flag_out_r)
                : (araddr == FLAG_DIR_OFS) ? 32'(flag_dir_r)
                : (araddr == STATUS_OFS) ? ((32'(!grant_n_s) << SB_GRANT) | (32'(ready_s) << SB_READY)
                  | (32'(busy) << SB_BUSY) | (32'(ack_s) << SB_ACK) | (32'(flag_s) << SB_FLAG))
                : 32'h00000000;

  function automatic logic wstrb_go(input logic [3:0] s);
    wstrb_go = s[0];
  endfunction

  // channel handshakes and register writes
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      aw_addr_r <= 8'h00;
      w_data_r <= 32'h00000000;
      w_strb_r <= 4'h0;
      awready <= 1'b1;
      wready <= 1'b1;
      bvalid <= 1'b0;
      bresp <= RESP_OKAY;
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= RESP_OKAY;
      ctrl_r <= '0;
      flag_out_r <= '1;
      flag_dir_r <= '0;
    end else begin
      if (aw_hs) begin
        aw_got_r <= 1'b1;
        aw_addr_r <= awaddr;
      end else if (do_write) begin
        aw_got_r <= 1'b0;
      end
      if (w_hs) begin
        w_got_r <= 1'b1;
        w_data_r <= wdata;
        w_strb_r <= wstrb;
      end else if (do_write) begin
        w_got_r <= 1'b0;
      end
      awready <= do_write || !(aw_got_r || aw_hs);
      wready <= do_write || !(w_got_r || w_hs);
      if (do_write) begin
        bvalid <= 1'b1;
        bresp <= wr_hit ? RESP_OKAY : RESP_DECERR;
      end else if (bready) begin
        bvalid <= 1'b0;
      end
      if (ar_hs) begin
        rvalid <= 1'b1;
        rdata <= rd_mux;
        rresp <= rd_hit ? RESP_OKAY : RESP_DECERR;
      end else if (rready) begin
        rvalid <= 1'b0;
      end
      arready <= !ar_hs && (!rvalid || rready);
      if (do_write && aw_addr_r == CTRL_OFS) begin
        ctrl_r <= CTRL_W'(merge(32'(ctrl_r), w_data_r, w_strb_r));
      end
      if (do_write && aw_addr_r == FLAG_OUT_OFS) begin
        flag_out_r <= FLAG_W'(merge(32'(flag_out_r), w_data_r, w_strb_r));
      end
      if (do_write && aw_addr_r == FLAG_DIR_OFS) begin
        flag_dir_r <= FLAG_W'(merge(32'(flag_dir_r), w_data_r, w_strb_r));
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // bus access as host after grant
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      H_IDLE: if (start) begin
        state_nxt = H_WAIT;
      end
      H_WAIT: if (!grant_n_s) begin
        state_nxt = H_ADDR;
      end
      H_ADDR: state_nxt = H_STROBE;
      H_STROBE: if (wait_cnt_r >= ACK_LATENCY_CYC && ready_s) begin
        state_nxt = H_IDLE;
      end
      default: state_nxt = H_IDLE;
    endcase
  end

  // access state and the registered pin drivers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_r <= H_IDLE;
      acc_write_r <= 1'b0;
      wait_cnt_r <= 4'h0;
      lnk.host_sw_oe <= 1'b0;
      lnk.host_sw_o <= 1'b1;
      lnk.host_wr_oe <= 1'b0;
      lnk.host_wr_o <= 1'b1;
      lnk.host_ack_oe <= 1'b0;
      lnk.host_ack_o <= 1'b0;
      lnk.host_request_n <= 1'b1;
      lnk.chip_select_n <= 1'b1;
      lnk.suspend_bus_float_n <= 1'b1;
      lnk.dma_request_channel_nine_n <= 1'b1;
      lnk.peer_bus_request_n <= 1'b1;
      lnk.irq_n <= '1;
      lnk.host_flag_o <= '1;
      lnk.host_flag_oe <= '0;
    end else begin
      state_r <= state_nxt;
      if (start) begin
        acc_write_r <= w_data_r[AB_WRITE];
      end
      wait_cnt_r <= (state_r != H_STROBE) ? 4'h0 : (wait_cnt_r < ACK_LATENCY_CYC) ? wait_cnt_r + 4'h1 : wait_cnt_r;
      lnk.host_sw_oe <= (state_nxt == H_ADDR) || (state_nxt == H_STROBE);
      lnk.host_sw_o <= !(state_nxt == H_ADDR && acc_write_r);
      lnk.host_wr_oe <= (state_nxt == H_ADDR) || (state_nxt == H_STROBE);
      lnk.host_wr_o <= !(state_nxt == H_STROBE && acc_write_r);
      // drive ack high for one cycle before release so the master's keeper settles high
      lnk.host_ack_oe <= ctrl_r[CB_ACKHOLD] || (lnk.host_ack_oe && !lnk.host_ack_o);
      lnk.host_ack_o <= !ctrl_r[CB_ACKHOLD];
      lnk.host_request_n <= !ctrl_r[CB_REQ];
      lnk.chip_select_n <= !ctrl_r[CB_CS];
      lnk.suspend_bus_float_n <= !ctrl_r[CB_SUSP];
      lnk.dma_request_channel_nine_n <= !ctrl_r[CB_DMA];
      lnk.peer_bus_request_n <= !ctrl_r[CB_PEER];
      lnk.irq_n <= ~ctrl_r[CB_IRQ +: IRQ_W];
      lnk.host_flag_o <= flag_out_r;
      lnk.host_flag_oe <= flag_dir_r;
    end
  end
endmodule
`default_nettype wire

// File: link_properties.sv
`timescale 1ns/1ps
`default_nettype none
module link_properties (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic host_request_n,
  input wire logic host_grant_n,
  input wire logic suspend_bus_float_n,
  input wire logic addr_bus_oe,
  input wire logic sdram_ctl_oe,
  input wire logic dev_wr_o,
  input wire logic dev_wr_oe,
  input wire logic dev_sw_o,
  input wire logic dev_sw_oe,
  input wire logic ack
);
  // single clock domain, checks paused in reset
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////
  // drive and float of the shared bus
  AST_SDRAM_DRIVEN: assert property (sdram_ctl_oe) else $error("sdram control floated");
  AST_GRANT_FLOATS: assert property (!host_grant_n |-> !addr_bus_oe && !dev_wr_oe && !dev_sw_oe) else $error("bus driven in grant");
  AST_SUSP_FLOAT: assert property ((!suspend_bus_float_n)[*4] |-> !addr_bus_oe && !dev_wr_oe) else $error("bus driven in suspend");
  AST_SW_WITH_ADDR: assert property (dev_sw_oe && !dev_sw_o |-> addr_bus_oe) else $error("early select without address");
  AST_SW_ONE_CYCLE: assert property (dev_sw_oe && !dev_sw_o |=> dev_sw_o || !dev_sw_oe) else $error("early select too long");
  AST_STROBE_LEN: assert property ($fell(dev_wr_o) && dev_wr_oe |-> (!dev_wr_o)[*5]) else $error("write strobe too short");
  AST_ACK_WAIT: assert property ((!ack)[*4] ##0 (dev_wr_oe && !dev_wr_o) |=> !dev_wr_o) else $error("strobe ended in wait");
  ////////////////////////////////////////////////////////////////
  // host grant arbitration
  AST_GRANT_SOON: assert property ($fell(host_request_n) |-> ##[2:60] !host_grant_n) else $error("grant late");
  AST_GRANT_HELD: assert property ((!host_request_n)[*4] ##0 !host_grant_n |=> !host_grant_n) else $error("grant dropped");
  AST_GRANT_DROP: assert property (host_request_n[*4] |-> host_grant_n) else $error("grant kept");
  // main scenarios reached
  cover property (!host_grant_n);
  cover property (dev_wr_oe && !dev_wr_o && !ack);
  cover property (!suspend_bus_float_n && !addr_bus_oe);
endmodule
`default_nettype wire

// File: testbench.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin bad_count++; $display("ERROR %s expected %0h seen %0h", nm, ex, got); end end
module testbench;
  import bus_port_pkg::*;
  logic sys_clk = 1'h0, rst = 1'h1;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic [31:0] wdata = 32'h0, system_configuration_register_wdata = 32'h0, rdata, system_configuration_register_rdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, rsp;
  logic access_req = 1'h0, access_write = 1'h0, access_abort = 1'h0, iop_ready = 1'h1, system_configuration_register_write = 1'h0;
  logic [IRQ_W-1:0] irq_edge_mode = 3'h1, irq_clear = 3'h0, irq_pending;
  logic [FLAG_W-1:0] flag_dir = 12'h0F0, flag_out = 12'h0A0, flag_in;
  logic access_done, access_stalled, iop_access, iop_write, dma_nine_request, host_granted;
  int bad_count = 0, n_compared = 0, cyc = 0, wr_low = 0;
  link_if lnk();
  bus_port_device i_bus_port_device (.sys_clk, .rst, .lnk(lnk), .access_req, .access_write, .access_abort,
    .access_done, .access_stalled, .iop_ready, .iop_access, .iop_write, .system_configuration_register_write, .system_configuration_register_wdata,
    .system_configuration_register_rdata, .irq_edge_mode, .irq_clear, .irq_pending, .flag_dir, .flag_out, .flag_in,
    .dma_nine_request, .host_granted);
  bus_port_host i_bus_port_host (.sys_clk, .rst, .lnk(lnk), .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready);
  link_properties i_link_properties (.sys_clk, .rst, .host_request_n(lnk.host_request_n),
    .host_grant_n(lnk.host_grant_n), .suspend_bus_float_n(lnk.suspend_bus_float_n),
    .addr_bus_oe(lnk.addr_bus_oe), .sdram_ctl_oe(lnk.sdram_ctl_oe), .dev_wr_o(lnk.dev_wr_o),
    .dev_wr_oe(lnk.dev_wr_oe), .dev_sw_o(lnk.dev_sw_o), .dev_sw_oe(lnk.dev_sw_oe), .ack(lnk.ack));
  ////////////////////////////////////////////////////////////////
  // clock, hang limit and strobe counter
  always #12.5 sys_clk = ~sys_clk;
  always @(posedge sys_clk) begin
    cyc++;
    if (!lnk.wr_n) wr_low++;
    if (cyc > 4000) begin
      bad_count++;
      finish_test();
    end
  end
  ////////////////////////////////////////////////////////////////
  // bus and access tasks
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w;
    @(posedge sys_clk);
    aw = 1'h0;
    w = 1'h0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(aw && w)) begin
      @(posedge sys_clk);
      if (awvalid && awready) begin
        aw = 1'h1;
        awvalid <= 1'h0;
      end
      if (wvalid && wready) begin
        w = 1'h1;
        wvalid <= 1'h0;
      end
    end
    do @(posedge sys_clk); while (!bvalid);
    rsp = bresp;
    bready <= 1'h0;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge sys_clk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do @(posedge sys_clk); while (!arready);
    arvalid <= 1'h0;
    do @(posedge sys_clk); while (!rvalid);
    rd = rdata;
    rsp = rresp;
    rready <= 1'h0;
  endtask
  task automatic go(input logic w, input logic ab);
    access_write <= w;
    access_abort <= ab;
    access_req <= 1'h1;
  endtask
  // drop the request once the address bus is driven, then await the end
  task automatic take();
    do @(posedge sys_clk); while (!lnk.addr_bus_oe);
    access_req <= 1'h0;
    do @(posedge sys_clk); while (!access_done);
    access_abort <= 1'h0;
  endtask
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    wt(5);
    rst <= 1'h0;
    wt(3);
    `CHK("grant idle", 1'h1, lnk.host_grant_n)
    `CHK("ready oe", 1'h0, lnk.dev_ready_oe)
    `CHK("config", 32'h0, system_configuration_register_rdata)
    axi_wr(8'h40, 32'h1);
    `CHK("unmapped wr", RESP_DECERR, rsp)
    axi_rd(8'h44);
    `CHK("unmapped rd", RESP_DECERR, rsp)
    // own write held by acknowledge low
    axi_wr(CTRL_OFS, 32'h20);
    wr_low = 0;
    go(1'h1, 1'h0);
    wt(20);
    `CHK("wait strobe", 1'h0, lnk.wr_n)
    axi_wr(CTRL_OFS, 32'h0);
    take();
    `CHK("long strobe", 1'h1, wr_low > 20)
    wr_low = 0;
    go(1'h1, 1'h1);
    take();
    `CHK("abort no strobe", 0, wr_low)
    // access under suspend
    axi_wr(CTRL_OFS, 32'h4);
    wt(3);
    go(1'h0, 1'h0);
    wt(10);
    `CHK("stalled", 1'h1, access_stalled)
    `CHK("bus floated", 1'h0, lnk.addr_bus_oe)
    axi_wr(CTRL_OFS, 32'h0);
    take();
    // host and peer request together, host write with waits
    axi_wr(CTRL_OFS, 32'h13);
    wt(8);
    `CHK("host wins", 1'h1, host_granted)
    `CHK("grant pin", 1'h0, lnk.host_grant_n)
    iop_ready <= 1'h0;
    axi_wr(ACCESS_OFS, 32'h3);
    wt(10);
    `CHK("ready wait", 1'h0, lnk.host_wait_ready)
    `CHK("slave write", 1'h1, iop_write)
    `CHK("slave access", 1'h1, iop_access)
    `CHK("strobe in", 1'h0, lnk.wr_n)
    iop_ready <= 1'h1;
    wt(10);
    axi_rd(STATUS_OFS);
    `CHK("host idle", 1'h0, rd[SB_BUSY])
    `CHK("grant bit", 1'h1, rd[SB_GRANT])
    system_configuration_register_wdata <= 32'h8;
    system_configuration_register_write <= 1'h1;
    wt(1);
    system_configuration_register_write <= 1'h0;
    wt(2);
    `CHK("drive mode", 1'h1, lnk.dev_ready_oe)
    axi_wr(CTRL_OFS, 32'h1);
    wt(8);
    `CHK("ready undriven", 1'h0, lnk.dev_ready_oe)
    axi_wr(CTRL_OFS, 32'h0);
    wt(8);
    `CHK("grant released", 1'h1, lnk.host_grant_n)
    // peer access to the registers, synchronous wait on ack
    iop_ready <= 1'h0;
    axi_wr(CTRL_OFS, 32'h12);
    wt(8);
    `CHK("slave ack wait", 1'h0, lnk.ack)
    iop_ready <= 1'h1;
    axi_wr(CTRL_OFS, 32'h0);
    wt(8);
    `CHK("ack kept high", 1'h1, lnk.ack)
    // interrupts, line 0 edge and the rest level
    axi_wr(CTRL_OFS, 32'h1C0);
    wt(5);
    `CHK("irq set", 3'h7, irq_pending)
    axi_wr(CTRL_OFS, 32'h0);
    wt(5);
    `CHK("irq edge kept", 3'h1, irq_pending)
    irq_clear <= 3'h1;
    wt(1);
    irq_clear <= 3'h0;
    wt(1);
    `CHK("irq cleared", 3'h0, irq_pending)
    // flags driven from both ends, dma request
    axi_wr(FLAG_DIR_OFS, 32'h00F);
    axi_wr(FLAG_OUT_OFS, 32'h005);
    axi_wr(CTRL_OFS, 32'h8);
    wt(5);
    `CHK("flags device", 12'hFA5, flag_in)
    `CHK("dma request", 1'h1, dma_nine_request)
    axi_rd(STATUS_OFS);
    `CHK("flags host", 12'hFA5, rd[27:16])
    finish_test();
  end
endmodule
`default_nettype wire
